// ---- hw/srt_pkg.sv ----
// Constants and types for the signaling relay trigger block
package srt_pkg;
  // ==========================================================
  // Sizes
  localparam int unsigned NSRC    = 8;
  localparam int unsigned SLOTS   = 4;
  localparam int unsigned NWORD   = 32;
  localparam int unsigned NRELAY  = 32;
  localparam int unsigned PER_CARD = 16;
  localparam int unsigned NSTUDIO = 4;
  localparam int unsigned CFG_W   = 17;
  localparam int unsigned CNT_W   = 23;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ADR_CMD   = 8'h80;
  localparam logic [7:0] ADR_TMPL  = 8'h84;
  localparam logic [7:0] ADR_STAT  = 8'h88;
  localparam logic [7:0] ADR_RELAY = 8'h8c;
  localparam logic [7:0] ADR_LAMP  = 8'h90;
  // ==========================================================
  // Slot word fields
  localparam int unsigned F_RELAY  = 0;
  localparam int unsigned F_CARD   = 4;
  localparam int unsigned F_RED    = 5;
  localparam int unsigned F_IMP    = 6;
  localparam int unsigned F_LONG   = 7;
  localparam int unsigned F_TRIG   = 8;
  localparam int unsigned F_PRESET = 13;
  localparam int unsigned F_STU_EN = 14;
  localparam int unsigned F_STU    = 15;
  localparam int unsigned F_VALID  = 31;
  // Trigger enable bits
  localparam int unsigned T_KEY1  = 0;
  localparam int unsigned T_KEY2  = 1;
  localparam int unsigned T_SEL   = 2;
  localparam int unsigned T_ON    = 3;
  localparam int unsigned T_FADER = 4;
  localparam logic [4:0]  FADER_START = 5'h1c;
  // Command fields
  localparam int unsigned C_NEW   = 8;
  localparam int unsigned C_CLEAR = 9;
  // ==========================================================
  // Reset values
  localparam logic [CFG_W-1:0] TMPL_RST = 17'h00000;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ         = 40000000;
  localparam int unsigned PULSE_SHORT_MS = 100;
  localparam int unsigned PULSE_LONG_MS  = 200;
  localparam int unsigned PULSE_SHORT_CYC = PULSE_SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned PULSE_LONG_CYC  = PULSE_LONG_MS * (CLK_HZ / 1000);
  // ==========================================================
  // Bus states
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_EXEC = 3'b010,
    BUS_ACK  = 3'b100
  } srt_bus_t;
endpackage

// ---- hw/srt_mem_if.sv ----
// Ports between the controller and the slot memory
`timescale 1ns/1ps
`default_nettype none
interface srt_mem_if;
  logic                     we;
  logic [4:0]               waddr;
  logic [srt_pkg::CFG_W-1:0] wdata;
  logic [4:0]               a_addr;
  logic [srt_pkg::CFG_W-1:0] a_rdata;
  logic [4:0]               b_addr;
  logic [srt_pkg::CFG_W-1:0] b_rdata;
  modport ctrl (output we, waddr, wdata, a_addr, b_addr, input a_rdata, b_rdata);
  modport mem  (input we, waddr, wdata, a_addr, b_addr, output a_rdata, b_rdata);
endinterface
`default_nettype wire

// ---- hw/srt_cfg_mem.sv ----
// Slot configuration memory, one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none
module srt_cfg_mem (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Memory ports
  srt_mem_if.mem   mif
);
  typedef struct packed {
    logic [srt_pkg::NWORD-1:0][srt_pkg::CFG_W-1:0] word;
    logic [srt_pkg::CFG_W-1:0]                     a_rd;
    logic [srt_pkg::CFG_W-1:0]                     b_rd;
  } srt_mem_state_t;

  srt_mem_state_t s_q;
  srt_mem_state_t s_d;

  // ==========================================================
  // Storage
  always_comb begin
    s_d = s_q;
    if (mif.we) begin
      s_d.word[mif.waddr] = mif.wdata;
    end
    s_d.a_rd = s_q.word[mif.a_addr];
    s_d.b_rd = s_q.word[mif.b_addr];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign mif.a_rdata = s_q.a_rd;
  assign mif.b_rdata = s_q.b_rd;

  a_rd_after_wr: assert property (@(posedge clk_i) disable iff (rst_i)
    (mif.we ##1 (mif.a_addr == $past(mif.waddr))) |=> (mif.a_rdata == $past(mif.wdata, 2)))
    else $error("bus port missed a write");
endmodule
`default_nettype wire

// ---- hw/srt_top.sv ----
// Signaling and red light relay trigger with Wishbone registers
// ==========================================================
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module srt_top #(
  parameter int unsigned PULSE_SHORT_CYC = srt_pkg::PULSE_SHORT_CYC,
  parameter int unsigned PULSE_LONG_CYC  = srt_pkg::PULSE_LONG_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Console state, one bit per source
  input  wire logic [7:0]  patched_i,
  input  wire logic [7:0]  key1_i,
  input  wire logic [7:0]  key2_i,
  input  wire logic [7:0]  in_sel_i,
  input  wire logic [7:0]  in_on_i,
  input  wire logic [7:0]  in_fader_i,
  input  wire logic [7:0]  route_master_i,
  input  wire logic [7:0]  route_group_i,
  input  wire logic [7:0]  group_open_i,
  input  wire logic [7:0]  mst_sel_i,
  input  wire logic [7:0]  mst_on_i,
  input  wire logic [7:0]  mst_fader_i,
  // Relay and lamp outputs
  output logic      [31:0] relay_o,
  output logic      [3:0]  studio_lamp_o
);
  localparam int unsigned NR = srt_pkg::NRELAY;
  localparam int unsigned CW = srt_pkg::CNT_W;

  typedef struct packed {
    srt_pkg::srt_bus_t                bus;
    logic                             ack;
    logic [31:0]                      rdat;
    logic [srt_pkg::NWORD-1:0]        valid;
    logic [srt_pkg::CFG_W-1:0]        tmpl;
    logic [1:0]                       last_slot;
    logic                             full;
    logic [4:0]                       idx;
    logic                             ev_vld;
    logic [4:0]                       ev_idx;
    logic [NR-1:0]                    acc;
    logic [NR-1:0]                    acc_imp;
    logic [NR-1:0]                    acc_long;
    logic [srt_pkg::NSTUDIO-1:0]      acc_stu;
    logic [NR-1:0]                    cond;
    logic [NR-1:0]                    imp;
    logic [NR-1:0]                    lng;
    logic [NR-1:0]                    prev;
    logic [NR-1:0]                    relay;
    logic [srt_pkg::NSTUDIO-1:0]      lamp;
    logic [NR-1:0][CW-1:0]            cnt;
  } srt_state_t;

  srt_state_t s_q;
  srt_state_t s_d;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  srt_mem_if mif ();

  srt_cfg_mem u_mem (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .mif   (mif)
  );

  // ==========================================================
  // Slot evaluation helpers
  logic [srt_pkg::CFG_W-1:0] ev_cfg;
  logic [2:0]                ev_src;
  logic [4:0]                ev_en;
  logic [4:0]                ev_rly;
  logic [1:0]                ev_stu;
  logic                      sig_path;
  logic                      red_path;
  logic                      ev_trig;
  logic                      ev_use;

  assign ev_cfg = mif.b_rdata;
  assign ev_src = s_q.ev_idx[4:2];
  assign ev_use = s_q.ev_vld & s_q.valid[s_q.ev_idx];
  // Card in the top bit, relay within card below it
  assign ev_rly = ev_cfg[srt_pkg::F_RELAY +: 5];
  assign ev_stu = ev_cfg[srt_pkg::F_STU +: 2];
  // Preset overrides the user choice
  assign ev_en  = ev_cfg[srt_pkg::F_PRESET] ? srt_pkg::FADER_START
                                            : ev_cfg[srt_pkg::F_TRIG +: 5];
  // Patch AND each enabled condition
  assign sig_path = patched_i[ev_src]
                  & (~ev_en[srt_pkg::T_KEY1]  | key1_i[ev_src])
                  & (~ev_en[srt_pkg::T_KEY2]  | key2_i[ev_src])
                  & (~ev_en[srt_pkg::T_SEL]   | in_sel_i[ev_src])
                  & (~ev_en[srt_pkg::T_ON]    | in_on_i[ev_src])
                  & (~ev_en[srt_pkg::T_FADER] | in_fader_i[ev_src]);
  // Fixed full path to a master output
  assign red_path = patched_i[ev_src] & in_sel_i[ev_src]
                  & in_fader_i[ev_src] & in_on_i[ev_src]
                  // Group route counts only when it reaches a master
                  & (route_master_i[ev_src]
                     | (route_group_i[ev_src] & group_open_i[ev_src]))
                  & mst_sel_i[ev_src] & mst_fader_i[ev_src] & mst_on_i[ev_src];
  assign ev_trig = ev_use & (ev_cfg[srt_pkg::F_RED] ? red_path : sig_path);

  // ==========================================================
  // Bus helpers
  logic        exec;
  logic        is_slot;
  logic [31:0] wmask;
  logic [2:0]  cmd_src;
  logic [4:0]  cmd_base;
  logic [3:0]  free;
  logic [1:0]  free_slot;
  logic        any_free;
  logic        cmd_wr;
  logic        new_cmd;
  logic        clr_cmd;
  logic [NR-1:0] rise_v;

  assign exec     = (s_q.bus == srt_pkg::BUS_EXEC);
  assign is_slot  = (wb_adr_i < srt_pkg::ADR_CMD);
  assign wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign cmd_src  = wb_dat_i[2:0];
  assign cmd_base = {cmd_src, 2'b00};
  assign free     = ~s_q.valid[cmd_base +: 4];
  assign any_free = |free;
  // Lowest unassigned slot
  assign free_slot = free[0] ? 2'd0 : free[1] ? 2'd1 : free[2] ? 2'd2 : 2'd3;
  assign cmd_wr   = exec & wb_we_i & (wb_adr_i == srt_pkg::ADR_CMD) & wb_sel_i[1];
  assign clr_cmd  = cmd_wr & wb_dat_i[srt_pkg::C_CLEAR];
  assign new_cmd  = cmd_wr & wb_dat_i[srt_pkg::C_NEW] & ~wb_dat_i[srt_pkg::C_CLEAR];
  assign rise_v   = s_q.cond & ~s_q.prev;

  // ==========================================================
  // Memory port use
  assign mif.a_addr = wb_adr_i[6:2];
  assign mif.b_addr = s_q.idx;
  assign mif.we     = (exec & wb_we_i & is_slot) | (new_cmd & any_free);
  assign mif.waddr  = is_slot ? wb_adr_i[6:2] : {cmd_src, free_slot};
  assign mif.wdata  = is_slot ? ((mif.a_rdata & ~wmask[srt_pkg::CFG_W-1:0])
                                 | (wb_dat_i[srt_pkg::CFG_W-1:0] & wmask[srt_pkg::CFG_W-1:0]))
                              : s_q.tmpl;

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    // Register access
    case (s_q.bus)
      srt_pkg::BUS_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          s_d.bus = srt_pkg::BUS_EXEC;
        end
      end
      srt_pkg::BUS_EXEC: begin
        s_d.bus = srt_pkg::BUS_ACK;
        s_d.ack = 1'b1;
        if (is_slot) begin
          s_d.rdat = {s_q.valid[wb_adr_i[6:2]], 14'h0000, mif.a_rdata};
        end else begin
          case (wb_adr_i)
            srt_pkg::ADR_TMPL:  s_d.rdat = {15'h0000, s_q.tmpl};
            srt_pkg::ADR_STAT:  s_d.rdat = {29'h00000000, s_q.full, s_q.last_slot};
            srt_pkg::ADR_RELAY: s_d.rdat = s_q.relay;
            srt_pkg::ADR_LAMP:  s_d.rdat = {28'h0000000, s_q.lamp};
            default:            s_d.rdat = 32'h00000000;
          endcase
        end
        if (wb_we_i && is_slot && wb_sel_i[3]) begin
          // Each slot holds its own assignment
          s_d.valid[wb_adr_i[6:2]] = wb_dat_i[srt_pkg::F_VALID];
        end
        if (wb_we_i && wb_adr_i == srt_pkg::ADR_TMPL) begin
          s_d.tmpl = (s_q.tmpl & ~wmask[srt_pkg::CFG_W-1:0])
                   | (wb_dat_i[srt_pkg::CFG_W-1:0] & wmask[srt_pkg::CFG_W-1:0]);
        end
        if (clr_cmd) begin
          s_d.valid[cmd_base +: 4] = 4'h0;
        end else if (new_cmd) begin
          s_d.full = ~any_free;
          if (any_free) begin
            s_d.valid[{cmd_src, free_slot}] = 1'b1;
            s_d.last_slot = free_slot;
          end
        end
      end
      srt_pkg::BUS_ACK: begin
        s_d.bus = srt_pkg::BUS_IDLE;
      end
      default: begin
        s_d.bus = srt_pkg::BUS_IDLE;
      end
    endcase
    // Slot scan, one slot per cycle
    s_d.idx    = s_q.idx + 5'd1;
    s_d.ev_vld = 1'b1;
    s_d.ev_idx = s_q.idx;
    if (ev_use) begin
      s_d.acc_imp[ev_rly]  = s_q.acc_imp[ev_rly] | ev_cfg[srt_pkg::F_IMP];
      s_d.acc_long[ev_rly] = s_q.acc_long[ev_rly] | ev_cfg[srt_pkg::F_LONG];
    end
    if (ev_trig) begin
      s_d.acc[ev_rly] = 1'b1;
      if (ev_cfg[srt_pkg::F_RED] && ev_cfg[srt_pkg::F_STU_EN]) begin
        s_d.acc_stu[ev_stu] = 1'b1;
      end
    end
    if (s_q.ev_vld && s_q.ev_idx == 5'h1f) begin
      s_d.cond     = s_d.acc;
      s_d.imp      = s_d.acc_imp;
      s_d.lng      = s_d.acc_long;
      s_d.lamp     = s_d.acc_stu;
      s_d.acc      = '0;
      s_d.acc_imp  = '0;
      s_d.acc_long = '0;
      s_d.acc_stu  = '0;
    end
    // Relay drive
    for (int r = 0; r < NR; r++) begin
      s_d.prev[r] = s_q.cond[r];
      if (!s_q.imp[r]) begin
        s_d.cnt[r] = '0;
      end else if (rise_v[r]) begin
        // Load only on a rising trigger
        s_d.cnt[r] = s_q.lng[r] ? CW'(PULSE_LONG_CYC) : CW'(PULSE_SHORT_CYC);
      end else if (s_q.cnt[r] != '0) begin
        s_d.cnt[r] = s_q.cnt[r] - 1'b1;
      end
      // Latching follows the trigger
      s_d.relay[r] = s_q.imp[r] ? (s_d.cnt[r] != '0) : s_q.cond[r];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q      <= '0;
      s_q.bus  <= srt_pkg::BUS_IDLE;
      s_q.tmpl <= srt_pkg::TMPL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign wb_dat_o      = s_q.rdat;
  assign wb_ack_o      = s_q.ack;
  assign relay_o       = s_q.relay;
  assign studio_lamp_o = s_q.lamp;

  // ==========================================================
  // Checks
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_ack_delay: assert property
    ((s_q.bus == srt_pkg::BUS_IDLE && wb_cyc_i && wb_stb_i) |-> ##2 wb_ack_o)
    else $error("ack not two cycles after request");

  a_latch_follow: assert property
    (((relay_o ^ $past(s_q.cond)) & ~$past(s_q.imp)) == '0)
    else $error("latching relay differs from trigger");

  a_pulse_start: assert property
    ((|(rise_v & s_q.imp)) |=> (($past(rise_v & s_q.imp) & ~relay_o) == '0))
    else $error("impulse relay did not close on rising trigger");

  a_no_retrig: assert property
    (((relay_o & ~$past(relay_o) & $past(s_q.imp)) & ~$past(rise_v)) == '0)
    else $error("impulse relay closed without rising trigger");

  a_clear_all: assert property (clr_cmd
    |=> (((s_q.valid >> $past(cmd_base)) & 32'h0000000f) == 32'h00000000))
    else $error("remove all left a slot assigned");

  a_new_lowest: assert property ((new_cmd && any_free)
    |=> (((s_q.valid >> $past(cmd_base)) & 32'h0000000f)
         == ((($past(s_q.valid) >> $past(cmd_base)) & 32'h0000000f)
             | (32'h00000001 << $past(free_slot)))))
    else $error("new assignment not in lowest free slot");

  a_red_gate: assert property
    ((ev_use && ev_cfg[srt_pkg::F_RED] && !red_path) |-> !ev_trig)
    else $error("red light fired without open path");

  a_fader_preset: assert property
    ((ev_use && !ev_cfg[srt_pkg::F_RED] && ev_cfg[srt_pkg::F_PRESET]
      && !in_fader_i[ev_src]) |-> !ev_trig)
    else $error("fader start preset ignored closed fader");

  a_or_combine: assert property
    ((s_q.ev_vld && s_q.ev_idx != 5'h1f)
     |=> ((($past(s_q.acc) & ~s_q.acc) == '0)
          && (!$past(ev_trig) || s_q.acc[$past(ev_rly)])))
    else $error("triggered source not ORed into relay");
endmodule
`default_nettype wire

// ---- verification/srt_relay_model.sv ----
// Relay bank model that times each contact closure
`timescale 1ns/1ps
`default_nettype none
module srt_relay_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Relay coils and measured closures
  input  wire logic [31:0] relay_i,
  output var int unsigned  len_o [32]
);
  int unsigned cnt_q [32];
  // ==========================================================
  // Length of the last closure per relay
  always_ff @(posedge clk_i) begin
    for (int b = 0; b < 32; b++) begin
      if (rst_i) begin
        cnt_q[b] <= 0;
        len_o[b] <= 0;
      end else if (relay_i[b] === 1'b1) begin
        cnt_q[b] <= cnt_q[b] + 1;
      end else if (cnt_q[b] != 0) begin
        len_o[b] <= cnt_q[b];
        cnt_q[b] <= 0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/srt_top_test.sv ----
// Self-checking bench for the signaling relay trigger
`timescale 1ns/1ps
`default_nettype none
module srt_top_test;
  localparam int unsigned SHORT = 20;
  localparam int unsigned LONG  = 40;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, dato, rdat, relay;
  logic [3:0]  lamp;
  logic [7:0]  pat = 8'h00, k1 = 8'h00, k2 = 8'h00, isel = 8'h00, ion = 8'h00, ifad = 8'h00;
  logic [7:0]  rm = 8'h00, rg = 8'h00, go = 8'h00, ms = 8'h00, mo = 8'h00, mf = 8'h00;
  int unsigned len [32];
  int          fails = 0, n_compared = 0;

  always #12.5 clk_i = ~clk_i;

  srt_top #(.PULSE_SHORT_CYC(SHORT), .PULSE_LONG_CYC(LONG)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack),
    .patched_i(pat), .key1_i(k1), .key2_i(k2), .in_sel_i(isel), .in_on_i(ion),
    .in_fader_i(ifad), .route_master_i(rm), .route_group_i(rg), .group_open_i(go),
    .mst_sel_i(ms), .mst_on_i(mo), .mst_fader_i(mf), .relay_o(relay), .studio_lamp_o(lamp));
  srt_relay_model MDL (.clk_i(clk_i), .rst_i(rst_i), .relay_i(relay), .len_o(len));

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_i);
    end
    if (ack !== 1'b1) chk(32'h0, 32'h1, "bus ack");
    rdat = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    wb(1'b0, a, 32'h0);
    chk(rdat, e, m);
  endtask
  task automatic wait_rel(input int b, input logic v, input string m);
    int n = 0;
    while (relay[b] !== v && n < 80) begin
      n++;
      @(posedge clk_i);
    end
    chk({31'h0, relay[b]}, {31'h0, v}, m);
  endtask
  task automatic settle();
    repeat (40) @(posedge clk_i);
  endtask
  task automatic set5(input int s, input logic [4:0] m);
    k1[s] <= m[0];
    k2[s] <= m[1];
    isel[s] <= m[2];
    ion[s] <= m[3];
    ifad[s] <= m[4];
  endtask
  task automatic path(input int s, input logic v);
    pat[s] <= v;
    isel[s] <= v;
    ifad[s] <= v;
    ion[s] <= v;
    ms[s] <= v;
    mo[s] <= v;
    mf[s] <= v;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk(relay, 32'h0, "relays after reset");
    chk({28'h0, lamp}, 32'h0, "lamps after reset");
    rd(srt_pkg::ADR_TMPL, 32'h0, "template reset");
    wb(1'b1, 8'h94, 32'hffffffff);
    rd(8'h94, 32'h0, "unmapped reads zero");
    rd(srt_pkg::ADR_CMD, 32'h0, "command reads zero");
  endtask
  task automatic t_alloc();
    wb(1'b1, srt_pkg::ADR_TMPL, 32'h00000103);
    rd(srt_pkg::ADR_TMPL, 32'h00000103, "template");
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, srt_pkg::ADR_CMD, 32'h100);
      rd(srt_pkg::ADR_STAT, 32'(k), "lowest free slot");
    end
    wb(1'b1, srt_pkg::ADR_CMD, 32'h100);
    rd(srt_pkg::ADR_STAT, 32'h7, "status after refusal");
    chk(rdat & 32'h4, 32'h4, "fifth assignment refused");
    rd(8'h0c, 32'h80000103, "slot three word");
    wb(1'b1, 8'h04, 32'h0);
    wb(1'b1, srt_pkg::ADR_CMD, 32'h100);
    rd(srt_pkg::ADR_STAT, 32'h1, "hole refilled");
  endtask
  task automatic t_latch();
    pat[0] <= 1'b1;
    settle();
    wait_rel(3, 1'b0, "key missing");
    k1[0] <= 1'b1;
    wait_rel(3, 1'b1, "latch closes");
    settle();
    wait_rel(3, 1'b1, "latch holds");
    k1[0] <= 1'b0;
    wait_rel(3, 1'b0, "latch opens");
  endtask
  task automatic t_or();
    wb(1'b1, 8'h10, 32'h80002003);
    pat[1] <= 1'b1;
    isel[1] <= 1'b1;
    ion[1] <= 1'b1;
    ifad[1] <= 1'b1;
    wait_rel(3, 1'b1, "fader start");
    ifad[1] <= 1'b0;
    wait_rel(3, 1'b0, "fader closed");
    k1[0] <= 1'b1;
    wait_rel(3, 1'b1, "first source");
    ifad[1] <= 1'b1;
    k1[0] <= 1'b0;
    settle();
    wait_rel(3, 1'b1, "second source holds");
    ifad[1] <= 1'b0;
    wait_rel(3, 1'b0, "both off");
  endtask
  task automatic t_all5();
    wb(1'b1, 8'h40, 32'h80001f07);
    pat[4] <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      set5(4, 5'h1f ^ (5'h01 << i));
      settle();
      wait_rel(7, 1'b0, "one condition off");
    end
    set5(4, 5'h1f);
    wait_rel(7, 1'b1, "all conditions");
    pat[4] <= 1'b0;
    wait_rel(7, 1'b0, "source unpatched");
  endtask
  task automatic t_pulse();
    wb(1'b1, 8'h20, 32'h80000045);
    wb(1'b1, 8'h24, 32'h800000c6);
    pat[2] <= 1'b1;
    wait_rel(5, 1'b1, "short pulse starts");
    repeat (60) @(posedge clk_i);
    chk(len[5], SHORT, "short pulse length");
    chk(len[6], LONG, "long pulse length");
    chk(relay & 32'h60, 32'h0, "no retrigger");
    pat[2] <= 1'b0;
    settle();
    pat[2] <= 1'b1;
    wait_rel(5, 1'b1, "new rise fires");
    pat[2] <= 1'b0;
    repeat (60) @(posedge clk_i);
  endtask
  task automatic t_red();
    wb(1'b1, 8'h30, 32'h80014032);
    path(3, 1'b1);
    settle();
    wait_rel(18, 1'b0, "not routed");
    rm[3] <= 1'b1;
    wait_rel(18, 1'b1, "open path card one");
    repeat (2) @(posedge clk_i);
    chk({28'h0, lamp}, 32'h4, "studio lamp on");
    rd(srt_pkg::ADR_LAMP, 32'h4, "lamp register");
    rd(srt_pkg::ADR_RELAY, 32'h00040000, "relay register");
    mf[3] <= 1'b0;
    wait_rel(18, 1'b0, "master fader shut");
    repeat (2) @(posedge clk_i);
    chk({28'h0, lamp}, 32'h0, "studio lamp off");
    mf[3] <= 1'b1;
    rm[3] <= 1'b0;
    rg[3] <= 1'b1;
    settle();
    wait_rel(18, 1'b0, "group path shut");
    go[3] <= 1'b1;
    wait_rel(18, 1'b1, "group path open");
    wb(1'b1, 8'h50, 32'h80014032);
    go[3] <= 1'b0;
    path(5, 1'b1);
    rm[5] <= 1'b1;
    settle();
    wait_rel(18, 1'b1, "second red source");
    path(5, 1'b0);
    wait_rel(18, 1'b0, "red sources off");
  endtask
  task automatic t_clear();
    k1[0] <= 1'b1;
    wb(1'b1, srt_pkg::ADR_CMD, 32'h200);
    rd(8'h00, 32'h00000103, "slot zero removed");
    rd(8'h0c, 32'h00000103, "slot three removed");
    settle();
    wait_rel(3, 1'b0, "removed source silent");
    wb(1'b1, srt_pkg::ADR_CMD, 32'h301);
    rd(8'h10, 32'h00002003, "remove beats new");
  endtask

  // ==========================================================
  // Sequence, watchdog and verdict
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_i);
    fails++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    final_report();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_alloc();
    t_latch();
    t_or();
    t_all5();
    t_pulse();
    t_red();
    t_clear();
    final_report();
  end
endmodule
`default_nettype wire
